// ---- verilog/sram_port_defs.vh ----
// constants for the dual-port sram port host controller
// assumes a 25 MHz core clock (40 ns period)
`ifndef SRAM_PORT_DEFS_VH
`define SRAM_PORT_DEFS_VH
// ***********************************
// timing figures in ns, and cycles
// ***********************************
`define CLK_PERIOD_NS 40
`define SELECT_TO_WRITE_END_NS 30
`define ADDR_TO_WRITE_END_NS 30
`define DATA_SETUP_TO_WRITE_END_NS 25
`define DATA_HOLD_AFTER_WRITE_NS 0
`define WRITE_RECOVERY_NS 0
`define WRITE_TO_FLOAT_NS 15
`define FLAG_WRITE_TO_READ_NS 10
`define READ_CYCLE_NS 35
`define OE_ACCESS_NS 20
`define OUT_HIGHZ_NS 15
`define CDIV_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMAX1(a) (((a) < 1) ? 1 : (a))
// write strobe width: float plus data setup, at least one cycle
`define WRITE_PULSE_CYC `CMAX1(`CDIV_UP(`WRITE_TO_FLOAT_NS + `DATA_SETUP_TO_WRITE_END_NS))
`define READ_ACCESS_CYC `CMAX1(`CDIV_UP(`READ_CYCLE_NS))
`define RECOVERY_CYC `CMAX1(`CDIV_UP(`WRITE_RECOVERY_NS))
`define FLAG_GAP_CYC `CMAX1(`CDIV_UP(`FLAG_WRITE_TO_READ_NS))
`define TURN_CYC `CMAX1(`CDIV_UP(`OUT_HIGHZ_NS))
`endif

// ---- verilog/sram_port_host.v ----
// host controller driving one port of an asynchronous dual-port static ram
// assumes the ram port pins are wired straight to this module and data pins
// are resolved from data_oe outside
//
// What this block does
// - hold read/write high through reads
// - address valid before select falls
// - each flag read gets own select
// - select combination held for whole access
// - address changes only with rw high
// - address held after strobe ends
// - select asserted 30 ns before write end
// - address valid 30 ns before write end
// - data 25 ns setup, 0 ns hold
// - own drivers off while ram drives
// - oe low: stretch write pulse
// - oe high, write pulse still sized for float plus setup
// - wait 10 ns write-to-read on flag
// - flag race winner not relied upon
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_defs.vh"
module sram_port_host #(
  parameter AW = 12, // address width
  parameter DW = 16 // data width
) (
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  input wire req_valid, // request strobe, same clock
  input wire req_write, // 1 write, 0 read
  input wire req_flag, // 1 semaphore flag, 0 array
  input wire [1:0] req_lanes, // bit1 upper, bit0 lower lane enables
  input wire [AW-1:0] req_addr,
  input wire [DW-1:0] req_wdata,
  output reg req_ready_r, // idle and accepting
  output reg rsp_valid_r, // one-cycle read answer / write done
  output reg [DW-1:0] rsp_rdata_r,
  output reg [AW-1:0] addr_r,
  output reg port_select_n_r,
  output reg flag_select_n_r,
  output reg upper_lane_sel_n_r,
  output reg lower_lane_sel_n_r,
  output reg rw_r, // 1 read, 0 write
  output reg out_enable_n_r,
  output reg [DW-1:0] data_out_r,
  output reg data_oe_r, // high while we drive data pins
  input wire [DW-1:0] data_in // pin data from ram
);
  // ***********************************
  // states and timing
  // ***********************************
  localparam [5:0] S_IDLE = 6'h01; // waiting for request
  localparam [5:0] S_RACC = 6'h02; // read access
  localparam [5:0] S_WSET = 6'h04; // rw and select fall together
  localparam [5:0] S_WSTB = 6'h08; // write strobe active
  localparam [5:0] S_REC = 6'h10; // recovery, lines high
  localparam [5:0] S_GAP = 6'h20; // turnaround / flag gap
  // cycle counts are worked out as integers, then cut to the counter width;
  // counts above 15 would need a wider counter
  localparam integer RD_CYC_I = `READ_ACCESS_CYC;
  localparam integer WR_CYC_I = `WRITE_PULSE_CYC;
  localparam integer REC_CYC_I = `RECOVERY_CYC;
  localparam integer GAP_CYC_I = (`FLAG_GAP_CYC > `TURN_CYC) ? `FLAG_GAP_CYC : `TURN_CYC;
  localparam [3:0] RD_CYC = RD_CYC_I[3:0];
  localparam [3:0] WR_CYC = WR_CYC_I[3:0];
  localparam [3:0] REC_CYC = REC_CYC_I[3:0];
  localparam [3:0] GAP_CYC = GAP_CYC_I[3:0];

  reg [5:0] state_r; // one-hot state
  reg addr_flag_r; // current access targets the flag space
  reg [3:0] cnt_r; // cycle counter within state
  reg was_write_r; // last access was a write
  reg [DW-1:0] din_s1_r; // pin sync first stage
  reg [DW-1:0] din_s2_r; // pin sync second stage

  // ***********************************
  // data pin synchroniser
  // ***********************************
  // data pins are asynchronous to us, so two stages before use
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      din_s1_r <= {DW{1'b0}};
      din_s2_r <= {DW{1'b0}};
    end else if (clk_en) begin
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
    end
  end

  // ***********************************
  // port sequencer
  // ***********************************
  // every pin is a flop; all selects return high between accesses so each
  // flag read gets its own select edge
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
      was_write_r <= 1'b0;
      req_ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= {DW{1'b0}};
      addr_r <= {AW{1'b0}};
      port_select_n_r <= 1'b1;
      flag_select_n_r <= 1'b1;
      upper_lane_sel_n_r <= 1'b1;
      lower_lane_sel_n_r <= 1'b1;
      rw_r <= 1'b1;
      out_enable_n_r <= 1'b1;
      data_out_r <= {DW{1'b0}};
      data_oe_r <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          req_ready_r <= 1'b1;
          if (req_valid && req_ready_r) begin
            req_ready_r <= 1'b0;
            // address moves only while rw and selects are high
            addr_r <= req_addr;
            upper_lane_sel_n_r <= req_flag | ~req_lanes[1];
            lower_lane_sel_n_r <= req_flag | ~req_lanes[0];
            was_write_r <= req_write;
            cnt_r <= 4'h0;
            if (req_write) begin
              // oe stays high on writes; the pulse is still sized for float plus setup
              // rw stays high this cycle: it must not move with the address
              data_out_r <= req_wdata;
              state_r <= S_WSET;
            end else begin
              // selects fall one cycle after address was driven
              state_r <= S_RACC;
            end
          end
        end
        S_WSET: begin
          // rw and select fall on one edge, so the ram floats its outputs;
          // an extra rw-first cycle would only lengthen every write
          rw_r <= 1'b0;
          // data driven only once ram is forced to float
          port_select_n_r <= addr_flag_r ? 1'b1 : 1'b0;
          flag_select_n_r <= addr_flag_r ? 1'b0 : 1'b1;
          data_oe_r <= 1'b1;
          state_r <= S_WSTB;
        end
        S_WSTB: begin
          // strobe held long enough for select, address and data setup,
          // even covering a float-plus-setup stretch
          if (cnt_r == WR_CYC - 4'h1) begin
            rw_r <= 1'b1; // rising rw ends the write; selects rise after
            cnt_r <= 4'h0;
            state_r <= S_REC;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        S_RACC: begin
          port_select_n_r <= addr_flag_r;
          flag_select_n_r <= ~addr_flag_r;
          out_enable_n_r <= 1'b0;
          if (cnt_r == RD_CYC + 4'h2) begin
            // two extra cycles let data cross the synchroniser
            rsp_rdata_r <= din_s2_r;
            rsp_valid_r <= 1'b1;
            cnt_r <= 4'h0;
            state_r <= S_REC;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        S_REC: begin
          // address and data held here after strobe ends
          port_select_n_r <= 1'b1;
          flag_select_n_r <= 1'b1;
          out_enable_n_r <= 1'b1;
          if (cnt_r == REC_CYC - 4'h1) begin
            data_oe_r <= 1'b0;
            upper_lane_sel_n_r <= 1'b1;
            lower_lane_sel_n_r <= 1'b1;
            if (was_write_r)
              rsp_valid_r <= 1'b1;
            cnt_r <= 4'h0;
            state_r <= S_GAP;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        S_GAP: begin
          // covers flag write-to-read gap and ram output turn-off
          if (cnt_r == GAP_CYC - 4'h1) begin
            cnt_r <= 4'h0;
            req_ready_r <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ***********************************
  // access target latch
  // ***********************************
  // flag grant outcome is read back as data; racing ports are not assumed
  // to win in any order
  // latched once at accept so the select pair cannot change mid access,
  // even if the requester moves req_flag while we are busy
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      addr_flag_r <= 1'b0;
    else if (clk_en && state_r == S_IDLE && req_valid && req_ready_r)
      addr_flag_r <= req_flag;
  end
endmodule // sram_port_host
`default_nettype wire

// ---- verification/sram_port_ram.sv ----
// model of one ram port: 4096 words plus eight flags
// assumes host pin names; drives data_in, the resolved data pins
`timescale 1ns/1ps
`default_nettype none
module sram_port_ram (
  input wire logic [11:0] addr_r,
  input wire logic port_select_n_r,
  input wire logic flag_select_n_r,
  input wire logic upper_lane_sel_n_r,
  input wire logic lower_lane_sel_n_r,
  input wire logic rw_r,
  input wire logic out_enable_n_r,
  input wire logic [15:0] data_out_r,
  input wire logic data_oe_r,
  output logic [15:0] data_in
);
  logic [15:0] mem [4096]; // array words
  logic [7:0] flag_r = 8'hff; // flags start released
  logic [15:0] noise = 16'h5a5a; // released pins wander, never hold a value
  wire ar = !port_select_n_r && flag_select_n_r; // array space
  wire fl = port_select_n_r && !flag_select_n_r; // flag space
  wire wr = !rw_r && (ar || fl); // strobe is the overlap
  wire rd = rw_r && !out_enable_n_r; // read drive window
  always #20 noise = ~noise;
  // cells follow the pins while the strobe lasts, so either edge may end it
  always @* begin
    if (wr && ar && !upper_lane_sel_n_r) mem[addr_r][15:8] = data_out_r[15:8];
    if (wr && ar && !lower_lane_sel_n_r) mem[addr_r][7:0] = data_out_r[7:0];
    if (wr && fl) flag_r[addr_r[2:0]] = data_out_r[0]; // lone port always wins
  end
  // chosen lanes are driven on array reads, all 16 bits on flag reads; pins float through writes
  always_comb begin
    data_in = data_oe_r ? data_out_r : noise;
    if (rd && ar && !upper_lane_sel_n_r) data_in[15:8] = mem[addr_r][15:8];
    if (rd && ar && !lower_lane_sel_n_r) data_in[7:0] = mem[addr_r][7:0];
    if (rd && fl) data_in = {16{flag_r[addr_r[2:0]]}};
  end
endmodule // sram_port_ram
`default_nettype wire

// ---- verification/sram_port_chk.sv ----
// assertions on the ram-side pins of the port host
// assumes bind onto sram_port_host, one clock domain
`timescale 1ns/1ps
`default_nettype none
module sram_port_chk #(
  parameter AW = 12
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [AW-1:0] addr_r,
  input wire logic port_select_n_r,
  input wire logic flag_select_n_r,
  input wire logic upper_lane_sel_n_r,
  input wire logic lower_lane_sel_n_r,
  input wire logic rw_r,
  input wire logic out_enable_n_r,
  input wire logic data_oe_r
);
  wire sel = !port_select_n_r || !flag_select_n_r; // some space selected
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence strobe_end; $rose(rw_r); endsequence
  AST_READ_RW: assert property (!out_enable_n_r |-> rw_r) else $error("oe low in write");
  AST_ADDR_QUIET: assert property ($changed(addr_r) |-> !sel && !$past(sel) && rw_r && $past(rw_r))
    else $error("addr moved");
  AST_ADDR_BEFORE_SEL: assert property ($fell(port_select_n_r) || $fell(flag_select_n_r) |-> $stable(addr_r))
    else $error("addr after select");
  AST_ADDR_HOLD: assert property (strobe_end |=> $stable(addr_r)) else $error("addr hold");
  AST_SPACE: assert property (port_select_n_r || flag_select_n_r) else $error("both spaces on");
  AST_LANE: assert property (!port_select_n_r |-> !(upper_lane_sel_n_r && lower_lane_sel_n_r)) else $error("no lane");
  AST_OE_OFF: assert property (data_oe_r || !rw_r |-> out_enable_n_r) else $error("bus clash");
  AST_SEL_SETUP: assert property (strobe_end |-> $past(sel)) else $error("select late");
  AST_ADDR_SETUP: assert property (strobe_end |-> addr_r == $past(addr_r, 2)) else $error("addr late");
  AST_DATA_SETUP: assert property (strobe_end |-> data_oe_r && $past(data_oe_r)) else $error("data late");
  AST_FLAG_GAP: assert property ($rose(flag_select_n_r) |=> flag_select_n_r) else $error("flag gap");
endmodule // sram_port_chk
bind sram_port_host sram_port_chk #(.AW(AW)) u_chk (.core_clk, .reset_n, .addr_r, .port_select_n_r,
  .flag_select_n_r, .upper_lane_sel_n_r, .lower_lane_sel_n_r, .rw_r, .out_enable_n_r, .data_oe_r);
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the ram port host
// assumes the ram model and checker files are compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 0, reset_n = 0, clk_en = 1, req_valid = 0, req_write = 0, req_flag = 0;
  logic [1:0] req_lanes = 0;
  logic [11:0] req_addr = 0, addr_r;
  logic [15:0] req_wdata = 0, rsp_rdata_r, data_out_r, data_in;
  logic req_ready_r, rsp_valid_r, port_select_n_r, flag_select_n_r, rw_r, out_enable_n_r, data_oe_r;
  logic upper_lane_sel_n_r, lower_lane_sel_n_r;
  int bad_count = 0, check_count = 0, cyc = 0;
  int m [16]; // expected array words
  int f [8] = '{default: 1}; // expected flags, released
  logic [31:0] seed = 32'h48cb;
  initial forever #20 core_clk = ~core_clk;
  sram_port_host u_sram_port_host (.core_clk, .reset_n, .clk_en, .req_valid, .req_write, .req_flag, .req_lanes,
    .req_addr, .req_wdata, .req_ready_r, .rsp_valid_r, .rsp_rdata_r, .addr_r, .port_select_n_r, .flag_select_n_r,
    .upper_lane_sel_n_r, .lower_lane_sel_n_r, .rw_r, .out_enable_n_r, .data_out_r, .data_oe_r, .data_in);
  sram_port_ram u_sram_port_ram (.addr_r, .port_select_n_r, .flag_select_n_r, .upper_lane_sel_n_r,
    .lower_lane_sel_n_r, .rw_r, .out_enable_n_r, .data_out_r, .data_oe_r, .data_in);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // one whole request: hold it until taken, then wait for the answer
  task automatic op(input bit w, input bit fl, input logic [1:0] ln, input logic [11:0] a,
    input logic [15:0] d, output logic [15:0] q);
    @(negedge core_clk);
    while (req_ready_r !== 1'b1) @(negedge core_clk);
    {req_valid, req_write, req_flag, req_lanes, req_addr, req_wdata} = {1'b1, w, fl, ln, a, d};
    do @(negedge core_clk); while (req_ready_r === 1'b1);
    req_valid = 0;
    while (rsp_valid_r !== 1'b1) @(negedge core_clk);
    q = rsp_rdata_r;
  endtask
  // cycle count, periodic clock-enable gaps, hang limit
  always @(negedge core_clk) begin
    cyc++;
    clk_en <= cyc[2:0] != 3'h5;
    if (cyc > 5000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    logic [15:0] q, mk;
    logic [11:0] a;
    logic [1:0] ln;
    int k;
    repeat (8) @(negedge core_clk);
    chk(req_ready_r === 1'b0 && rw_r === 1'b1 && data_oe_r === 1'b0, "reset pins");
    reset_n = 1;
    $display("test reset done");
    for (a = 0; a < 16; a++) begin
      seed = nxt(seed);
      m[a] = {16'h0, seed[15:0]};
      op(1, 0, 2'b11, a, seed[15:0], q);
    end
    $display("test fill done");
    for (k = 0; k < 80; k++) begin
      seed = nxt(seed);
      a = {8'h0, seed[11:8]};
      ln = (seed[4:3] == 2'b00) ? 2'b11 : seed[4:3];
      mk = {{8{ln[1]}}, {8{ln[0]}}};
      op(seed[0], seed[1] & seed[2], ln, a, seed[31:16], q);
      if (seed[1] & seed[2] & seed[0]) f[a[2:0]] = {31'h0, seed[16]};
      else if (seed[1] & seed[2]) chk(q === {16{f[a[2:0]][0]}}, "flag read");
      else if (seed[0]) m[a] = {16'h0, (m[a][15:0] & ~mk) | (seed[31:16] & mk)};
      else chk((q & mk) === (m[a][15:0] & mk), "array read");
    end
    $display("test random done");
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
